// ---- caac_defines.vh ----
// Register map, field positions, reset values for the aux control bank
// ****************************************************************
// What this block does
// - Left ADC_HIGH_PASS_FILTER uses programmable coefficients when set
// - Right ADC_HIGH_PASS_FILTER uses programmable coefficients when set
// - ADC feeds programmable filter only DACs down
// - Bit clear enables hang detector and recovery
// - Read-only hang status shows detected bus hang
// - Reading hang status register clears it
// - Right bypass bits close right line switches
// - Left bypass bits close left line switches
// - Two-bit field picks DAC reference current
// - Registers 110-127 read zero, never written
// - Page select bit picks active page
// - Register zero is page select on both pages
// - Coefficient is 16-bit two's-complement from MSB/LSB
// - N0 MSB resets to 0x6b, read/write
// ****************************************************************
`ifndef CAAC_DEFINES_VH
`define CAAC_DEFINES_VH

// Register indices
`define CAAC_PAGE_SEL_ADDR     7'h00
`define CAAC_N0_HIGH_ADDR      7'h01
`define CAAC_N0_LOW_ADDR       7'h02
`define CAAC_ADC_BUS_ADDR      7'h6b
`define CAAC_BYPASS_ADDR       7'h6c
`define CAAC_DAC_CUR_ADDR      7'h6d
`define CAAC_RSVD_FIRST_ADDR   7'h6e
`define CAAC_RSVD_LAST_ADDR    7'h7f

// Reset values
`define CAAC_PAGE_SEL_RST      8'h00
`define CAAC_N0_HIGH_RST       8'h6b
`define CAAC_N0_LOW_RST        8'he3
`define CAAC_ADC_BUS_RST       8'h00
`define CAAC_BYPASS_RST        8'h00
`define CAAC_DAC_CUR_RST       8'h00
`define CAAC_RSVD_VALUE        8'h00

// Field positions in the ADC path and bus condition register
`define CAAC_HPF_LEFT_BIT      7
`define CAAC_HPF_RIGHT_BIT     6
`define CAAC_FILT_PATH_BIT     3
`define CAAC_HANG_DIS_BIT      2
`define CAAC_HANG_RSVD_BIT     1
`define CAAC_HANG_STAT_BIT     0

// Field positions in the bypass register
`define CAAC_L2RP_BIT          6
`define CAAC_L1RM_BIT          5
`define CAAC_L1RP_BIT          4
`define CAAC_L2LP_BIT          2
`define CAAC_L1LM_BIT          1
`define CAAC_L1LP_BIT          0

// DAC current field and codes
`define CAAC_DAC_CUR_HI        7
`define CAAC_DAC_CUR_LO        6
`define CAAC_DAC_CUR_DEFAULT   2'h0
`define CAAC_DAC_CUR_HALF_UP   2'h1
`define CAAC_DAC_CUR_RESERVED  2'h2
`define CAAC_DAC_CUR_DOUBLE    2'h3

// Page select field
`define CAAC_PAGE_BIT          0

`endif

// ---- caac_coef_stage.v ----
// Coefficient MSB staging and 16-bit commit on LSB write
`timescale 1ns/10ps
`include "caac_defines.vh"

module caac_coef_stage #(
  parameter [7:0] HIGH_RST = `CAAC_N0_HIGH_RST,
  parameter [7:0] LOW_RST  = `CAAC_N0_LOW_RST
) (
  input  wire        clock_in,
  input  wire        rst_n_in,
  input  wire        high_wr_in,
  input  wire        low_wr_in,
  input  wire [7:0]  wdata_in,
  output wire [7:0]  high_byte_out,
  output wire [7:0]  low_byte_out,
  output wire [15:0] coef_out
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  reg [7:0]  high_stage_ff;
  reg [7:0]  low_byte_ff;
  reg [15:0] coef_ff;

  // Stage MSB, commit whole word on LSB write
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      high_stage_ff <= HIGH_RST;
      low_byte_ff   <= LOW_RST;
      coef_ff       <= {HIGH_RST, LOW_RST};
    end else begin
      if (high_wr_in) begin
        high_stage_ff <= wdata_in;
      end
      if (low_wr_in) begin
        low_byte_ff <= wdata_in;
        coef_ff     <= {high_stage_ff, wdata_in};
      end
    end
  end

  assign high_byte_out = high_stage_ff;
  assign low_byte_out  = low_byte_ff;
  assign coef_out      = coef_ff;

endmodule // caac_coef_stage

// ---- caac_aux_regs.v ----
// Aux control register bank: ADC path, bus hang, bypass, DAC current, page
`timescale 1ns/10ps
`include "caac_defines.vh"

module caac_aux_regs #(
  parameter ADDR_W = 7,
  parameter DATA_W = 8
) (
  input  wire              clock_in,
  input  wire              rst_n_in,
  // Register access port from the control bus engine
  input  wire [ADDR_W-1:0] reg_addr_in,
  input  wire              reg_wr_in,
  input  wire              reg_rd_in,
  input  wire [DATA_W-1:0] reg_wdata_in,
  output reg  [DATA_W-1:0] reg_rdata_out,
  output reg               reg_rvalid_out,
  // Status from the rest of the device
  input  wire              bus_hang_event_in,
  input  wire              dacs_powered_down_in,
  // Controls to the datapath and analog
  output reg               hpf_left_prog_out,
  output reg               hpf_right_prog_out,
  output reg               adc_prog_filter_out,
  output reg               hang_detect_enable_out,
  output reg               line_two_right_plus_out,
  output reg               line_one_right_minus_out,
  output reg               line_one_right_plus_out,
  output reg               line_two_left_plus_out,
  output reg               line_one_left_minus_out,
  output reg               line_one_left_plus_out,
  output reg  [1:0]        dac_current_sel_out,
  output reg               active_page_out,
  output reg  [15:0]       effects_coefficient_zero_out
);

  // ****************************************************************
  // Address decode helper
  // ****************************************************************

  // True when the access hits a given index on a given page
  function hit;
    input [ADDR_W-1:0] addr;
    input              page;
    input [ADDR_W-1:0] want_addr;
    input              want_page;
    begin
      hit = (addr == want_addr) && (page == want_page);
    end
  endfunction

  // Reserved block on page zero
  function in_rsvd;
    input [ADDR_W-1:0] addr;
    input              page;
    begin
      in_rsvd = !page && (addr >= `CAAC_RSVD_FIRST_ADDR) &&
                (addr <= `CAAC_RSVD_LAST_ADDR);
    end
  endfunction

  // ****************************************************************
  // Registers
  // ****************************************************************
  reg              page_sel_ff;
  reg [7:0]        adc_bus_ff;
  reg              hang_stat_ff;
  reg [7:0]        bypass_ff;
  reg [7:0]        dac_cur_ff;
  reg [DATA_W-1:0] nxt_rdata;
  reg              nxt_hang_stat;
  reg [1:0]        nxt_dac_cur;

  wire       page_hit;
  wire       adc_bus_hit;
  wire       bypass_hit;
  wire       dac_cur_hit;
  wire       n0_high_hit;
  wire       n0_low_hit;
  wire [7:0] n0_high_byte;
  wire [7:0] n0_low_byte;
  wire [15:0] n0_coef;
  wire       adc_bus_read;

  // Register zero decodes to the page selector on either page
  assign page_hit    = (reg_addr_in == `CAAC_PAGE_SEL_ADDR);
  // Remaining decodes use the active page
  assign adc_bus_hit = hit(reg_addr_in, page_sel_ff,
                           `CAAC_ADC_BUS_ADDR, 1'b0);
  assign bypass_hit  = hit(reg_addr_in, page_sel_ff,
                           `CAAC_BYPASS_ADDR, 1'b0);
  assign dac_cur_hit = hit(reg_addr_in, page_sel_ff,
                           `CAAC_DAC_CUR_ADDR, 1'b0);
  assign n0_high_hit = hit(reg_addr_in, page_sel_ff,
                           `CAAC_N0_HIGH_ADDR, 1'b1);
  assign n0_low_hit  = hit(reg_addr_in, page_sel_ff,
                           `CAAC_N0_LOW_ADDR, 1'b1);
  assign adc_bus_read = reg_rd_in && adc_bus_hit;

  // ****************************************************************
  // Software writable registers
  // ****************************************************************

  // Page selector, reserved upper bits never stored
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      page_sel_ff <= 1'b0;
    end else if (reg_wr_in && page_hit) begin
      page_sel_ff <= reg_wdata_in[`CAAC_PAGE_BIT];
    end
  end

  // ADC path and bus condition controls; bits 1:0 are not stored here
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      adc_bus_ff <= `CAAC_ADC_BUS_RST;
    end else if (reg_wr_in && adc_bus_hit) begin
      adc_bus_ff <= {reg_wdata_in[7:2], 2'h0};
    end
  end

  // Bypass switch selection, reserved bits kept as written
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bypass_ff <= `CAAC_BYPASS_RST;
    end else if (reg_wr_in && bypass_hit) begin
      bypass_ff <= reg_wdata_in;
    end
  end

  // DAC quiescent current adjust
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dac_cur_ff <= `CAAC_DAC_CUR_RST;
    end else if (reg_wr_in && dac_cur_hit) begin
      dac_cur_ff <= reg_wdata_in;
    end
  end

  // Writes into the reserved block are dropped by having no decode

  // ****************************************************************
  // Bus hang status
  // ****************************************************************

  // Sticky hang flag; a new event beats the read clear
  always @* begin
    nxt_hang_stat = hang_stat_ff;
    if (adc_bus_read) begin
      nxt_hang_stat = 1'b0;
    end
    if (bus_hang_event_in && !adc_bus_ff[`CAAC_HANG_DIS_BIT]) begin
      nxt_hang_stat = 1'b1;
    end
  end

  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hang_stat_ff <= 1'b0;
    end else begin
      hang_stat_ff <= nxt_hang_stat;
    end
  end

  // ****************************************************************
  // Effects coefficient N0
  // ****************************************************************
  caac_coef_stage #(
    .HIGH_RST (`CAAC_N0_HIGH_RST),
    .LOW_RST  (`CAAC_N0_LOW_RST)
  ) u_n0_stage (
    .clock_in      (clock_in),
    .rst_n_in      (rst_n_in),
    .high_wr_in    (reg_wr_in && n0_high_hit),
    .low_wr_in     (reg_wr_in && n0_low_hit),
    .wdata_in      (reg_wdata_in),
    .high_byte_out (n0_high_byte),
    .low_byte_out  (n0_low_byte),
    .coef_out      (n0_coef)
  );

  // ****************************************************************
  // Read data
  // ****************************************************************

  // Read mux against the active page
  always @* begin
    nxt_rdata = {DATA_W{1'b0}};
    if (page_hit) begin
      nxt_rdata = {7'h00, page_sel_ff};
    end else if (adc_bus_hit) begin
      nxt_rdata = {adc_bus_ff[7:2], 1'b0, hang_stat_ff};
    end else if (bypass_hit) begin
      nxt_rdata = bypass_ff;
    end else if (dac_cur_hit) begin
      nxt_rdata = dac_cur_ff;
    end else if (in_rsvd(reg_addr_in, page_sel_ff)) begin
      nxt_rdata = `CAAC_RSVD_VALUE;
    end else if (n0_high_hit) begin
      nxt_rdata = n0_high_byte;
    end else if (n0_low_hit) begin
      nxt_rdata = n0_low_byte;
    end
  end

  // Read answer one cycle after the strobe
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out  <= {DATA_W{1'b0}};
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in) begin
        reg_rdata_out <= nxt_rdata;
      end
    end
  end

  // ****************************************************************
  // Control outputs
  // ****************************************************************

  // Reserved current code falls back to default current
  always @* begin
    case (dac_cur_ff[`CAAC_DAC_CUR_HI:`CAAC_DAC_CUR_LO])
      `CAAC_DAC_CUR_HALF_UP: nxt_dac_cur = `CAAC_DAC_CUR_HALF_UP;
      `CAAC_DAC_CUR_DOUBLE:  nxt_dac_cur = `CAAC_DAC_CUR_DOUBLE;
      default:               nxt_dac_cur = `CAAC_DAC_CUR_DEFAULT;
    endcase
  end

  // Registered copies of every control
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hpf_left_prog_out            <= 1'b0;
      hpf_right_prog_out           <= 1'b0;
      adc_prog_filter_out          <= 1'b0;
      hang_detect_enable_out       <= 1'b0;
      line_two_right_plus_out      <= 1'b0;
      line_one_right_minus_out     <= 1'b0;
      line_one_right_plus_out      <= 1'b0;
      line_two_left_plus_out       <= 1'b0;
      line_one_left_minus_out      <= 1'b0;
      line_one_left_plus_out       <= 1'b0;
      dac_current_sel_out          <= 2'h0;
      active_page_out              <= 1'b0;
      effects_coefficient_zero_out <= {`CAAC_N0_HIGH_RST, `CAAC_N0_LOW_RST};
    end else begin
      hpf_left_prog_out   <= adc_bus_ff[`CAAC_HPF_LEFT_BIT];
      hpf_right_prog_out  <= adc_bus_ff[`CAAC_HPF_RIGHT_BIT];
      adc_prog_filter_out <= adc_bus_ff[`CAAC_FILT_PATH_BIT] &&
                             dacs_powered_down_in;
      hang_detect_enable_out <= !adc_bus_ff[`CAAC_HANG_DIS_BIT];
      line_two_right_plus_out  <= bypass_ff[`CAAC_L2RP_BIT];
      line_one_right_minus_out <= bypass_ff[`CAAC_L1RM_BIT];
      line_one_right_plus_out  <= bypass_ff[`CAAC_L1RP_BIT];
      line_two_left_plus_out   <= bypass_ff[`CAAC_L2LP_BIT];
      line_one_left_minus_out  <= bypass_ff[`CAAC_L1LM_BIT];
      line_one_left_plus_out   <= bypass_ff[`CAAC_L1LP_BIT];
      dac_current_sel_out      <= nxt_dac_cur;
      active_page_out          <= page_sel_ff;
      effects_coefficient_zero_out <= n0_coef;
    end
  end

endmodule // caac_aux_regs

// ---- caac_aux_regs_monitor.sv ----
// Checker for the aux control register bank
`timescale 1ns/10ps
module caac_aux_regs_monitor (
  input logic        clock_in,
  input logic        rst_n_in,
  input logic [6:0]  reg_addr_in,
  input logic        reg_wr_in,
  input logic        reg_rd_in,
  input logic [7:0]  reg_wdata_in,
  input logic [7:0]  reg_rdata_out,
  input logic        reg_rvalid_out,
  input logic        dacs_powered_down_in,
  input logic        hpf_left_prog_out,
  input logic        hpf_right_prog_out,
  input logic        adc_prog_filter_out,
  input logic        hang_detect_enable_out,
  input logic        line_two_right_plus_out,
  input logic        line_one_right_minus_out,
  input logic        line_one_right_plus_out,
  input logic        line_two_left_plus_out,
  input logic        line_one_left_minus_out,
  input logic        line_one_left_plus_out,
  input logic [1:0]  dac_current_sel_out,
  input logic        active_page_out,
  input logic [15:0] effects_coefficient_zero_out
);
  // Page write one edge ago leaves the page output stale
  logic pg_wr_ff;
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) pg_wr_ff <= 1'b0;
    else pg_wr_ff <= reg_wr_in && reg_addr_in == 7'h00;
  end
  wire p0_ok = !active_page_out && !pg_wr_ff;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  a_hpf_sel_follow: assert property (
    p0_ok && reg_wr_in && reg_addr_in == 7'h6b |-> ##2
    {hpf_left_prog_out, hpf_right_prog_out} == $past(reg_wdata_in[7:6], 2))
    else $error("hpf select mismatch");
  a_hang_en_follow: assert property (
    p0_ok && reg_wr_in && reg_addr_in == 7'h6b |-> ##2
    hang_detect_enable_out == !$past(reg_wdata_in[2], 2))
    else $error("hang enable mismatch");
  a_bypass_follow: assert property (
    p0_ok && reg_wr_in && reg_addr_in == 7'h6c |-> ##2
    {line_two_right_plus_out, line_one_right_minus_out,
     line_one_right_plus_out, line_two_left_plus_out,
     line_one_left_minus_out, line_one_left_plus_out} ==
    {$past(reg_wdata_in[6:4], 2), $past(reg_wdata_in[2:0], 2)})
    else $error("bypass mismatch");
  a_dac_code_map: assert property (
    p0_ok && reg_wr_in && reg_addr_in == 7'h6d |-> ##2
    dac_current_sel_out == ($past(reg_wdata_in[7:6], 2) == 2'b10 ?
    2'b00 : $past(reg_wdata_in[7:6], 2)))
    else $error("dac current mismatch");
  a_filter_gated: assert property (
    adc_prog_filter_out |-> $past(dacs_powered_down_in))
    else $error("filter path while dac on");
  a_coef_commit: assert property (
    $changed(effects_coefficient_zero_out) |->
    $past(reg_wr_in && reg_addr_in == 7'h02, 2))
    else $error("coefficient changed without low write");
  a_page_follow: assert property (
    reg_wr_in && reg_addr_in == 7'h00 |-> ##2
    active_page_out == $past(reg_wdata_in[0], 2))
    else $error("page mismatch");
  a_rsvd_read_zero: assert property (
    p0_ok && reg_rd_in && reg_addr_in >= 7'h6e |=> reg_rdata_out == 8'h00)
    else $error("reserved read not zero");
  a_read_answer: assert property (
    reg_rd_in |=> reg_rvalid_out)
    else $error("read not answered");
endmodule // caac_aux_regs_monitor

bind caac_aux_regs caac_aux_regs_monitor u_mon (
  .clock_in(clock_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
  .reg_rvalid_out(reg_rvalid_out),
  .dacs_powered_down_in(dacs_powered_down_in),
  .hpf_left_prog_out(hpf_left_prog_out),
  .hpf_right_prog_out(hpf_right_prog_out),
  .adc_prog_filter_out(adc_prog_filter_out),
  .hang_detect_enable_out(hang_detect_enable_out),
  .line_two_right_plus_out(line_two_right_plus_out),
  .line_one_right_minus_out(line_one_right_minus_out),
  .line_one_right_plus_out(line_one_right_plus_out),
  .line_two_left_plus_out(line_two_left_plus_out),
  .line_one_left_minus_out(line_one_left_minus_out),
  .line_one_left_plus_out(line_one_left_plus_out),
  .dac_current_sel_out(dac_current_sel_out),
  .active_page_out(active_page_out),
  .effects_coefficient_zero_out(effects_coefficient_zero_out));

// ---- caac_host_model.sv ----
// Host model issuing register accesses
`timescale 1ns/10ps
module caac_host_model (
  input  wire       clock_in,
  output reg  [6:0] addr_out,
  output reg        wr_out,
  output reg        rd_out,
  output reg  [7:0] wdata_out
);
  // Bus idle at time zero
  initial begin
    {addr_out, wr_out, rd_out, wdata_out} = 17'h00000;
  end
  // One access per clock, cleared by the next call
  task op(input w, input r, input [6:0] a, input [7:0] d);
    @(posedge clock_in);
    wr_out    <= w;
    rd_out    <= r;
    addr_out  <= a;
    wdata_out <= d;
  endtask
  // Idle cycle scrambles address and data
  task idle();
    op(1'b0, 1'b0, ~addr_out, ~wdata_out);
  endtask
  // Page write, reserved bits zero
  task page_wr(input p);
    op(1'b1, 1'b0, 7'h00, {7'h00, p});
  endtask
  // High byte then low byte, back to back
  task coef_wr(input [15:0] c);
    op(1'b1, 1'b0, 7'h01, c[15:8]);
    op(1'b1, 1'b0, 7'h02, c[7:0]);
  endtask
endmodule // caac_host_model

// ---- test_codec_aux_control_registers.sv ----
// Self-checking bench for the aux control register bank
`timescale 1ns/10ps
module test_codec_aux_control_registers;
  reg         clock_in = 1'b0;
  reg         rst_n_in = 1'b0;
  reg         hang_ev = 1'b0;
  reg         dacs_dn = 1'b0;
  wire [6:0]  addr;
  wire        wr, rd, rvalid, hl, hr, apf, hen, pg;
  wire [7:0]  wdata, rdata;
  wire [5:0]  byp;
  wire [1:0]  dac;
  wire [15:0] coef;
  integer     failures = 0;
  integer     num_checks = 0;
  integer     seed = 32'h91ceceb9;
  integer     i;
  reg  [7:0]  v;
  reg  [7:0]  exp_q[$];

  always #5 clock_in = ~clock_in;

  caac_host_model host (.clock_in(clock_in), .addr_out(addr),
    .wr_out(wr), .rd_out(rd), .wdata_out(wdata));
  caac_aux_regs dut (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .bus_hang_event_in(hang_ev), .dacs_powered_down_in(dacs_dn),
    .hpf_left_prog_out(hl), .hpf_right_prog_out(hr),
    .adc_prog_filter_out(apf), .hang_detect_enable_out(hen),
    .line_two_right_plus_out(byp[5]), .line_one_right_minus_out(byp[4]),
    .line_one_right_plus_out(byp[3]), .line_two_left_plus_out(byp[2]),
    .line_one_left_minus_out(byp[1]), .line_one_left_plus_out(byp[0]),
    .dac_current_sel_out(dac), .active_page_out(pg),
    .effects_coefficient_zero_out(coef));

  task check(input [15:0] seen, input [15:0] exp, input string nm);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task settle();
    host.idle();
    repeat (3) @(posedge clock_in);
    #1;
  endtask
  task wr_reg(input [6:0] a, input [7:0] d);
    host.op(1'b1, 1'b0, a, d);
    settle();
  endtask
  task rd_reg(input [6:0] a, input [7:0] e);
    exp_q.push_back(e);
    host.op(1'b0, 1'b1, a, 8'h00);
    settle();
  endtask
  task pulse();
    @(posedge clock_in) hang_ev <= 1'b1;
    @(posedge clock_in) hang_ev <= 1'b0;
  endtask
  task end_sim();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Read data compared with the oldest note
  always @(posedge clock_in) begin
    if (rvalid === 1'b1) begin
      if (exp_q.size() == 0) check(rdata, 16'hffff, "rdata_extra");
      else check(rdata, exp_q.pop_front(), "rdata");
    end
  end

  // Watchdog
  initial begin
    #100000;
    failures = failures + 1;
    end_sim();
  end

  initial begin
    repeat (4) @(posedge clock_in);
    rst_n_in <= 1'b1;
    rd_reg(7'h00, 8'h00);
    rd_reg(7'h6b, 8'h00);
    check({hl, hr, apf, hen}, 4'b0001, "ctl_rst");
    @(posedge clock_in) dacs_dn <= 1'b1;
    wr_reg(7'h6b, 8'hcd);
    check({hl, hr, apf, hen}, 4'b1110, "ctl_set");
    pulse();
    rd_reg(7'h6b, 8'hcc);
    @(posedge clock_in) dacs_dn <= 1'b0;
    settle();
    check(apf, 16'h0, "filter_dac_on");
    wr_reg(7'h6b, 8'h00);
    pulse();
    rd_reg(7'h6b, 8'h01);
    rd_reg(7'h6b, 8'h00);
    for (i = 0; i < 4; i = i + 1) begin
      v = (i == 0) ? 8'h33 : (i == 1) ? 8'h44 : 8'($random(seed));
      v = v & {2'b01, 1'b1, ~v[6], 3'b011, ~v[2]};
      wr_reg(7'h6c, v);
      check(byp, {v[6:4], v[2:0]}, "bypass");
      rd_reg(7'h6c, v);
    end
    for (i = 0; i < 4; i = i + 1) begin
      wr_reg(7'h6d, {i[1:0], 6'h00});
      check(dac, (i == 2) ? 2'b00 : i[1:0], "dac_cur");
    end
    wr_reg(7'h6a, 8'ha5);
    rd_reg(7'h70, 8'h00);
    rd_reg(7'h7f, 8'h00);
    host.page_wr(1'b1);
    settle();
    check(pg, 16'h1, "page");
    rd_reg(7'h00, 8'h01);
    rd_reg(7'h01, 8'h6b);
    rd_reg(7'h02, 8'he3);
    rd_reg(7'h6c, 8'h00);
    v = 8'($random(seed));
    host.coef_wr({v, 8'h3c});
    host.idle();
    #1;
    check(coef, 16'h6be3, "coef_hold");
    settle();
    check(coef, {v, 8'h3c}, "coef_new");
    rd_reg(7'h01, v);
    host.coef_wr({8'h80, v});
    settle();
    check(coef, {8'h80, v}, "coef");
    host.page_wr(1'b0);
    exp_q.push_back(8'h00);
    exp_q.push_back(8'hc0);
    host.op(1'b0, 1'b1, 7'h00, 8'h00);
    host.op(1'b0, 1'b1, 7'h6d, 8'h00);
    settle();
    host.page_wr(1'b1);
    settle();
    @(posedge clock_in) rst_n_in <= 1'b0;
    @(posedge clock_in) #1;
    check({hl, hr, apf, hen, byp, dac, pg}, 16'h0, "rst_outs");
    check(coef, 16'h6be3, "rst_coef");
    @(posedge clock_in) rst_n_in <= 1'b1;
    rd_reg(7'h00, 8'h00);
    check(exp_q.size(), 16'h0, "reads_left");
    end_sim();
  end
endmodule // test_codec_aux_control_registers
